// ===== design/port_role_pkg.sv
// Package with constants and carrier types for the Type-C port role control block
package port_role_pkg;

    // Port-role field encodings
    localparam logic [1:0] ROLE_DRP0     = 2'h0;
    localparam logic [1:0] ROLE_SINK     = 2'h1;
    localparam logic [1:0] ROLE_SOURCE   = 2'h2;
    localparam logic [1:0] ROLE_DRP1     = 2'h3;
    localparam logic [1:0] ROLE_RESET    = 2'h0;
    localparam int         ROLE_FIELD_HI = 5;
    localparam int         ROLE_FIELD_LO = 4;
    localparam int         SOFT_RST_BIT  = 3;

    // Target address when the address strap is low
    localparam logic [6:0] ADDR_STRAP_LOW = 7'h47;

    // Dual-role toggle half period
    localparam int DRP_HALF_US     = 50;
    localparam int CLK_MHZ         = 10;
    localparam int DRP_HALF_CYCLES = DRP_HALF_US * CLK_MHZ;

    // Attach debounce time
    localparam int DEB_US     = 20;
    localparam int DEB_CYCLES = DEB_US * CLK_MHZ;

    // Strap conditions
    typedef enum logic [1:0] {
        STRAP_LOW   = 2'h0,
        STRAP_HIGH  = 2'h1,
        STRAP_FLOAT = 2'h2
    } strap_e;

    // Attach states, Gray coded
    typedef enum logic [2:0] {
        ST_UNATT_SNK = 3'h0,
        ST_UNATT_SRC = 3'h1,
        ST_ATT_SRC   = 3'h3,
        ST_ATT_SNK   = 3'h2
    } att_state_e;

    // Status as seen by software
    typedef struct packed {
        logic       attached;
        logic       as_source;
        logic       cable_dir;
        logic [1:0] role_sel;
    } status_s;

    // Synchronised pin levels from the link side
    typedef struct packed {
        logic cc1_rd_seen;
        logic cc2_rd_seen;
        logic cc1_rp_seen;
        logic cc2_rp_seen;
        logic bus_power;
        logic enable_n;
    } link_pins_s;

endpackage

// ===== design/typec_port_role_control.sv
// Port role, attach and orientation control for a Type-C configuration channel
`timescale 1ns/10ps

// Behaviour
// RULE1 - Either strap level selects host-register control mode
// RULE2 - Strap at ground gives address 0x47
// RULE3 - Register content change asserts interrupt low
// RULE4 - Dual-role attached as source drives indicator low
// RULE5 - Controller enables bus power only after indicator
// RULE6 - Controller acts as device when powered, indicator high
// RULE7 - Orientation output follows detected cable side
// RULE8 - Orientation flag 0 CC1, 1 CC2
// RULE9 - Role 10 source only, 01 sink only
// RULE10 - Leave fixed role on change, reset, enable fall
// RULE11 - Dual-role alternates sink and source until attach
// RULE12 - Unpowered presents pull-downs on both CC
// RULE13 - After reset enter unattached sink, dual-role
// RULE14 - Software writes role field for fixed role
// RULE15 - Source watches CC, sink watches bus power
// RULE16 - Successful attach enters active mode
// RULE17 - Role 00 and 11 mean dual-role
// RULE18 - Soft reset clears attach state, self clears
// RULE19 - Indicator released on detach or sink attach
module typec_port_role_control
(
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 addr_strap_high_i,
    input  wire logic                 addr_strap_low_i,
    input  wire logic                 enable_n_i,
    input  wire logic                 bus_power_sense_i,
    input  wire logic                 cc1_rd_seen_i,
    input  wire logic                 cc2_rd_seen_i,
    input  wire logic                 cc1_rp_seen_i,
    input  wire logic                 cc2_rp_seen_i,
    input  wire logic                 role_wr_i,
    input  wire logic [1:0]           role_wdata_i,
    input  wire logic                 soft_reset_wr_i,
    input  wire logic                 status_read_i,
    output logic                      reg_mode_o,
    output logic [6:0]                target_addr_o,
    output logic                      addr_valid_o,
    output port_role_pkg::status_s    status_o,
    output logic                      active_o,
    output logic                      cc_pull_up_o,
    output logic                      cc_pull_down_o,
    output logic                      irq_out_n_o,
    output logic                      irq_out_n_oe_o,
    output logic                      otg_role_indicator_o,
    output logic                      otg_role_indicator_oe_o,
    output logic                      orient_o
);

    // Three-stage synchronisers for pin inputs
    port_role_pkg::link_pins_s pins_raw;
    port_role_pkg::link_pins_s s1_r, s2_r, s3_r, stable_r;
    port_role_pkg::link_pins_s s1_nxt, s2_nxt, s3_nxt, stable_nxt;

    assign pins_raw = '{cc1_rd_seen: cc1_rd_seen_i, cc2_rd_seen: cc2_rd_seen_i,
                        cc1_rp_seen: cc1_rp_seen_i, cc2_rp_seen: cc2_rp_seen_i,
                        bus_power: bus_power_sense_i, enable_n: enable_n_i};

    // A change counts once stages two and three agree, per bit
    always_comb
    begin
        s1_nxt     = pins_raw;
        s2_nxt     = s1_r;
        s3_nxt     = s2_r;
        stable_nxt = stable_r;
        for (int i = 0; i < $bits(port_role_pkg::link_pins_s); i++)
        begin
            if (s2_r[i] == s3_r[i])
            begin
                stable_nxt[i] = s3_r[i];
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            s1_r     <= '0;
            s2_r     <= '0;
            s3_r     <= '0;
            stable_r <= '0;
        end
        else
        begin
            s1_r     <= s1_nxt;
            s2_r     <= s2_nxt;
            s3_r     <= s3_nxt;
            stable_r <= stable_nxt;
        end
    end

    // Strap capture, taken on the cycle after reset release
    port_role_pkg::strap_e strap_r, strap_nxt;
    logic                  strap_done_r, strap_done_nxt;

    always_comb
    begin
        strap_nxt      = strap_r;
        strap_done_nxt = 1'b1;
        if (!strap_done_r)
        begin
            if (addr_strap_low_i)
                strap_nxt = port_role_pkg::STRAP_LOW;
            else if (addr_strap_high_i)
                strap_nxt = port_role_pkg::STRAP_HIGH;
            else
                strap_nxt = port_role_pkg::STRAP_FLOAT;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            strap_r      <= port_role_pkg::STRAP_FLOAT;
            strap_done_r <= 1'b0;
        end
        else
        begin
            strap_r      <= strap_nxt;
            strap_done_r <= strap_done_nxt;
        end
    end

    // Mode and address from the strap
    assign reg_mode_o    = strap_done_r && (strap_r != port_role_pkg::STRAP_FLOAT); // RULE1
    assign addr_valid_o  = strap_done_r && (strap_r == port_role_pkg::STRAP_LOW);
    assign target_addr_o = addr_valid_o ? port_role_pkg::ADDR_STRAP_LOW : 7'h00; // RULE2

    // Role field and soft reset pulse
    logic [1:0] role_r, role_nxt;
    logic       restart;
    logic       en_fall;
    logic       en_prev_r, en_prev_nxt;

    assign en_fall     = en_prev_r && !stable_r.enable_n;
    assign en_prev_nxt = stable_r.enable_n;

    always_comb
    begin
        role_nxt = role_r;
        if (role_wr_i && reg_mode_o)
            role_nxt = role_wdata_i; // RULE9 RULE14
    end

    // Role change, soft reset or enable fall restart the attach machine
    assign restart = (role_nxt != role_r) || soft_reset_wr_i || en_fall; // RULE10 RULE18

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            role_r    <= port_role_pkg::ROLE_RESET; // RULE17
            en_prev_r <= 1'b0;
        end
        else
        begin
            role_r    <= role_nxt;
            en_prev_r <= en_prev_nxt;
        end
    end

    logic is_drp, is_src_only, is_snk_only;
    assign is_drp      = (role_r == port_role_pkg::ROLE_DRP0) || (role_r == port_role_pkg::ROLE_DRP1); // RULE17
    assign is_src_only = (role_r == port_role_pkg::ROLE_SOURCE); // RULE9
    assign is_snk_only = (role_r == port_role_pkg::ROLE_SINK); // RULE9

    // Attach state machine with toggle and debounce counters
    port_role_pkg::att_state_e st_r, st_nxt;
    logic [15:0] tog_r, tog_nxt;
    logic [15:0] deb_r, deb_nxt;
    logic        dir_r, dir_nxt;
    logic        src_cond, snk_cond, cond;

    assign src_cond = stable_r.cc1_rd_seen || stable_r.cc2_rd_seen; // RULE15
    assign snk_cond = stable_r.bus_power; // RULE15
    assign cond     = (st_r == port_role_pkg::ST_UNATT_SRC) ? src_cond : snk_cond;

    always_comb
    begin
        st_nxt  = st_r;
        tog_nxt = tog_r;
        deb_nxt = deb_r;
        dir_nxt = dir_r;
        unique case (st_r)
            port_role_pkg::ST_UNATT_SNK, port_role_pkg::ST_UNATT_SRC:
            begin
                deb_nxt = cond ? deb_r + 16'h0001 : 16'h0000;
                tog_nxt = tog_r + 16'h0001;
                if (cond && deb_r == 16'(port_role_pkg::DEB_CYCLES - 1))
                begin
                    deb_nxt = 16'h0000;
                    tog_nxt = 16'h0000;
                    if (st_r == port_role_pkg::ST_UNATT_SRC)
                    begin
                        st_nxt  = port_role_pkg::ST_ATT_SRC; // RULE16
                        dir_nxt = stable_r.cc2_rd_seen && !stable_r.cc1_rd_seen; // RULE8
                    end
                    else
                    begin
                        st_nxt  = port_role_pkg::ST_ATT_SNK; // RULE16
                        dir_nxt = stable_r.cc2_rp_seen && !stable_r.cc1_rp_seen; // RULE8
                    end
                end
                else if (is_drp && !cond && tog_r >= 16'(port_role_pkg::DRP_HALF_CYCLES - 1))
                begin
                    tog_nxt = 16'h0000;
                    st_nxt  = (st_r == port_role_pkg::ST_UNATT_SNK) ? port_role_pkg::ST_UNATT_SRC
                                                                     : port_role_pkg::ST_UNATT_SNK; // RULE11
                end
                else if (!is_drp && tog_r >= 16'(port_role_pkg::DRP_HALF_CYCLES - 1))
                begin
                    tog_nxt = 16'h0000;
                end
            end
            port_role_pkg::ST_ATT_SRC:
            begin
                if (!src_cond)
                    st_nxt = port_role_pkg::ST_UNATT_SNK;
            end
            port_role_pkg::ST_ATT_SNK:
            begin
                if (!snk_cond)
                    st_nxt = port_role_pkg::ST_UNATT_SNK;
            end
            default:
                st_nxt = port_role_pkg::ST_UNATT_SNK;
        endcase
        // Fixed roles pin the unattached state
        if (st_nxt == port_role_pkg::ST_UNATT_SNK && is_src_only)
            st_nxt = port_role_pkg::ST_UNATT_SRC;
        if (st_nxt == port_role_pkg::ST_UNATT_SRC && is_snk_only)
            st_nxt = port_role_pkg::ST_UNATT_SNK;
        if (restart)
        begin
            st_nxt  = (role_nxt == port_role_pkg::ROLE_SOURCE) ? port_role_pkg::ST_UNATT_SRC
                                                               : port_role_pkg::ST_UNATT_SNK; // RULE10
            tog_nxt = 16'h0000;
            deb_nxt = 16'h0000;
            dir_nxt = 1'b0; // RULE18
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            st_r  <= port_role_pkg::ST_UNATT_SNK; // RULE13
            tog_r <= 16'h0000;
            deb_r <= 16'h0000;
            dir_r <= 1'b0;
        end
        else
        begin
            st_r  <= st_nxt;
            tog_r <= tog_nxt;
            deb_r <= deb_nxt;
            dir_r <= dir_nxt;
        end
    end

    // Status view and terminations
    port_role_pkg::status_s status_r, status_nxt;
    logic                   irq_r, irq_nxt;
    logic                   ind_r, ind_nxt;

    always_comb
    begin
        status_nxt.attached  = (st_r == port_role_pkg::ST_ATT_SRC) || (st_r == port_role_pkg::ST_ATT_SNK);
        status_nxt.as_source = (st_r == port_role_pkg::ST_ATT_SRC) || (st_r == port_role_pkg::ST_UNATT_SRC);
        status_nxt.cable_dir = dir_r; // RULE8
        status_nxt.role_sel  = role_r;
        // Any status change raises the interrupt; a read clears it, a change wins
        irq_nxt = irq_r;
        if (status_read_i)
            irq_nxt = 1'b0;
        if (status_nxt != status_r)
            irq_nxt = 1'b1; // RULE3
        // Indicator low only in dual-role attached source
        ind_nxt = is_drp && (st_r == port_role_pkg::ST_ATT_SRC); // RULE4 RULE19
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            status_r <= '0;
            irq_r    <= 1'b0;
            ind_r    <= 1'b0;
        end
        else
        begin
            status_r <= status_nxt;
            irq_r    <= irq_nxt;
            ind_r    <= ind_nxt;
        end
    end

    assign status_o                = status_r;
    assign active_o                = status_r.attached; // RULE16
    // Rd is the default, also in reset, matching the unpowered state
    assign cc_pull_down_o          = !status_r.as_source; // RULE12
    assign cc_pull_up_o            = status_r.as_source;
    assign irq_out_n_o             = 1'b0;
    assign irq_out_n_oe_o          = irq_r; // RULE3
    assign otg_role_indicator_o    = 1'b0;
    assign otg_role_indicator_oe_o = ind_r; // RULE4 RULE5 RULE6 RULE19
    assign orient_o                = status_r.cable_dir; // RULE7

endmodule

// ===== test/port_role_asserts.sv
// Checker watching the port role control outputs
`timescale 1ns/10ps
module port_role_asserts
(
    input wire logic                   core_clk_i,
    input wire logic                   rst_i,
    input wire logic                   bus_power_sense_i,
    input wire logic                   cc1_rd_seen_i,
    input wire logic                   cc2_rd_seen_i,
    input wire logic                   soft_reset_wr_i,
    input wire logic                   status_read_i,
    input wire logic                   reg_mode_o,
    input wire logic [6:0]             target_addr_o,
    input wire logic                   addr_valid_o,
    input wire port_role_pkg::status_s status_o,
    input wire logic                   active_o,
    input wire logic                   irq_out_n_oe_o,
    input wire logic                   otg_role_indicator_o,
    input wire logic                   otg_role_indicator_oe_o,
    input wire logic                   orient_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    addr_low_a: assert property (addr_valid_o |-> target_addr_o == 7'h47 && reg_mode_o)
        else $error("strap low address wrong");
    ind_only_a: assert property (otg_role_indicator_oe_o |-> status_o.attached && status_o.as_source
        && status_o.role_sel[1] == status_o.role_sel[0] && !otg_role_indicator_o)
        else $error("indicator driven outside dual-role source attach");
    ind_on_a: assert property (status_o.attached && status_o.as_source
        && status_o.role_sel[1] == status_o.role_sel[0] |-> otg_role_indicator_oe_o)
        else $error("indicator not driven on dual-role source attach");
    orient_out_a: assert property (active_o && $past(active_o) |-> $stable(orient_o)
        && orient_o == status_o.cable_dir)
        else $error("orientation pin moved or disagrees with status");
    irq_set_a: assert property ($changed(status_o) |-> irq_out_n_oe_o)
        else $error("status change did not raise interrupt");
    irq_hold_a: assert property (irq_out_n_oe_o && !status_read_i |=> irq_out_n_oe_o)
        else $error("interrupt dropped without read");
    irq_clear_a: assert property (status_read_i ##1 !$changed(status_o) |-> !irq_out_n_oe_o)
        else $error("read did not clear interrupt");
    sink_power_a: assert property ($rose(active_o) && !status_o.as_source |-> bus_power_sense_i)
        else $error("sink attach without bus power");
    fixed_role_a: assert property (status_o.role_sel inside {2'h1, 2'h2}
        |-> status_o.as_source == status_o.role_sel[1])
        else $error("fixed role not kept");
    soft_leave_a: assert property (soft_reset_wr_i |-> ##[1:3] !active_o)
        else $error("soft reset did not detach");
    active_mode_a: assert property ($rose(active_o) && status_o.as_source |-> cc1_rd_seen_i || cc2_rd_seen_i)
        else $error("source attach without partner termination");
endmodule

bind typec_port_role_control port_role_asserts i_port_role_asserts
(
    .core_clk_i, .rst_i, .bus_power_sense_i, .cc1_rd_seen_i, .cc2_rd_seen_i, .soft_reset_wr_i, .status_read_i,
    .reg_mode_o,
    .target_addr_o, .addr_valid_o, .status_o, .active_o, .irq_out_n_oe_o,
    .otg_role_indicator_o, .otg_role_indicator_oe_o, .orient_o
);

// ===== test/cc_partner.sv
// Port partner model across the CC lines
`timescale 1ns/10ps
module cc_partner
(
    input  wire logic       core_clk_i,
    input  wire logic [1:0] kind_i,
    input  wire logic       flip_i,
    input  wire logic       pull_up_i,
    input  wire logic       pull_down_i,
    output logic            cc1_rd_o,
    output logic            cc2_rd_o,
    output logic            cc1_rp_o,
    output logic            cc2_rp_o,
    output logic            bus_power_o
);
    // Kind 1 is a sink showing Rd, kind 2 a source showing Rp and bus power
    always_ff @(posedge core_clk_i)
    begin
        cc1_rd_o    <= kind_i == 2'h1 && pull_up_i && !flip_i;
        cc2_rd_o    <= kind_i == 2'h1 && pull_up_i && flip_i;
        cc1_rp_o    <= kind_i == 2'h2 && pull_down_i && !flip_i;
        cc2_rp_o    <= kind_i == 2'h2 && pull_down_i && flip_i;
        bus_power_o <= kind_i == 2'h2;
    end
endmodule

// ===== test/testbench.sv
// Self-checking bench for the port role control block
`timescale 1ns/10ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin errors++; $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module testbench;
    logic                    core_clk_i = 1'b0;
    logic                    rst_i = 1'b1;
    logic                    addr_strap_high_i, addr_strap_low_i, enable_n_i, role_wr_i;
    logic                    soft_reset_wr_i, status_read_i, bus_power_sense_i;
    logic                    cc1_rd_seen_i, cc2_rd_seen_i, cc1_rp_seen_i, cc2_rp_seen_i;
    logic [1:0]              role_wdata_i, kind, rsel;
    logic                    reg_mode_o, addr_valid_o, active_o, cc_pull_up_o, cc_pull_down_o;
    logic                    irq_out_n_o, irq_out_n_oe_o, otg_role_indicator_o, otg_role_indicator_oe_o, orient_o;
    logic [6:0]              target_addr_o;
    port_role_pkg::status_s  status_o;
    logic                    flip, first;
    logic [5:0]              exp_v;
    logic [5:0]              exp_q[$];
    int                      errors = 0;
    int                      compares = 0;

    typec_port_role_control i_typec_port_role_control
    (
        .core_clk_i, .rst_i, .addr_strap_high_i, .addr_strap_low_i, .enable_n_i, .bus_power_sense_i,
        .cc1_rd_seen_i, .cc2_rd_seen_i, .cc1_rp_seen_i, .cc2_rp_seen_i, .role_wr_i, .role_wdata_i,
        .soft_reset_wr_i, .status_read_i, .reg_mode_o, .target_addr_o, .addr_valid_o, .status_o,
        .active_o, .cc_pull_up_o, .cc_pull_down_o, .irq_out_n_o, .irq_out_n_oe_o,
        .otg_role_indicator_o, .otg_role_indicator_oe_o, .orient_o
    );

    cc_partner i_cc_partner
    (
        .core_clk_i, .kind_i(kind), .flip_i(flip), .pull_up_i(cc_pull_up_o), .pull_down_i(cc_pull_down_o),
        .cc1_rd_o(cc1_rd_seen_i), .cc2_rd_o(cc2_rd_seen_i), .cc1_rp_o(cc1_rp_seen_i),
        .cc2_rp_o(cc2_rp_seen_i), .bus_power_o(bus_power_sense_i)
    );

    // Clock at 100 ns period
    initial
    forever #50 core_clk_i = ~core_clk_i;

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask

    // Bounded wait for the attach flag to reach a level
    task automatic wait_act(input logic v);
        for (int k = 0; k < 3000 && active_o !== v; k++)
            cyc(1);
        `CHK("active", v, active_o)
    endtask

    task automatic wrap_up;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Each attach takes the oldest expected status off the queue
    initial
    forever
    begin
        @(posedge active_o);
        #1;
        exp_v = exp_q.size() ? exp_q.pop_front() : 6'h00;
        `CHK("attach_status", exp_v, {status_o, orient_o})
    end

    initial
    begin
        repeat (20000) @(posedge core_clk_i);
        errors++;
        $display("watchdog expired");
        wrap_up;
    end

    initial
    begin
        {addr_strap_high_i, enable_n_i, role_wr_i, soft_reset_wr_i, status_read_i} = 5'h00;
        addr_strap_low_i = 1'b1;
        role_wdata_i = 2'h0;
        kind = 2'h0;
        flip = 1'b0;
        void'($urandom(53));
        cyc(5);
        rst_i = 1'b0;
        cyc(2);
        `CHK("pull_down", 1'b1, cc_pull_down_o)
        `CHK("pull_up", 1'b0, cc_pull_up_o)
        `CHK("status", 5'h00, status_o)
        `CHK("reg_mode", 1'b1, reg_mode_o)
        `CHK("addr", 7'h47, target_addr_o)
        `CHK("addr_valid", 1'b1, addr_valid_o)
        cyc(250);
        first = status_o.as_source;
        cyc(500);
        `CHK("toggle", ~first, status_o.as_source)
        $display("reset and toggle done");
        rsel = ($urandom % 2) ? 2'h3 : 2'h0;
        flip = 1'($urandom % 2);
        role_wdata_i = rsel;
        pulse(role_wr_i);
        exp_q.push_back({1'b1, 1'b1, flip, rsel, flip});
        kind = 2'h1;
        wait_act(1'b1);
        cyc(2);
        `CHK("indicator_on", 1'b1, otg_role_indicator_oe_o)
        `CHK("irq_on", 1'b1, irq_out_n_oe_o)
        `CHK("irq_level", 1'b0, irq_out_n_o)
        pulse(status_read_i);
        cyc(1);
        `CHK("irq_clear", 1'b0, irq_out_n_oe_o)
        kind = 2'h0;
        wait_act(1'b0);
        `CHK("indicator_off", 1'b0, otg_role_indicator_oe_o)
        $display("dual-role source attach done");
        flip = 1'($urandom % 2);
        role_wdata_i = 2'h1;
        pulse(role_wr_i);
        exp_q.push_back({1'b1, 1'b0, flip, 2'h1, flip});
        kind = 2'h2;
        wait_act(1'b1);
        `CHK("indicator_sink", 1'b0, otg_role_indicator_oe_o)
        role_wdata_i = 2'h2;
        pulse(role_wr_i);
        wait_act(1'b0);
        cyc(300);
        `CHK("source_ignores_power", 1'b0, active_o)
        $display("fixed sink done");
        // CC2 side so that the soft reset visibly clears the orientation
        flip = 1'b1;
        exp_q.push_back({1'b1, 1'b1, flip, 2'h2, flip});
        kind = 2'h1;
        wait_act(1'b1);
        `CHK("indicator_fixed", 1'b0, otg_role_indicator_oe_o)
        pulse(soft_reset_wr_i);
        wait_act(1'b0);
        `CHK("orient_reset", 1'b0, orient_o)
        // Partner still present, so the source attaches again
        exp_q.push_back({1'b1, 1'b1, flip, 2'h2, flip});
        wait_act(1'b1);
        enable_n_i = 1'b1;
        cyc(8);
        enable_n_i = 1'b0;
        wait_act(1'b0);
        kind = 2'h0;
        $display("fixed source, soft reset and enable fall done");
        // Mid-run resets with the strap pulled high, then floating
        addr_strap_low_i = 1'b0;
        addr_strap_high_i = 1'b1;
        rst_i = 1'b1;
        cyc(5);
        rst_i = 1'b0;
        cyc(2);
        `CHK("reg_mode_high", 1'b1, reg_mode_o)
        `CHK("addr_valid_high", 1'b0, addr_valid_o)
        addr_strap_high_i = 1'b0;
        rst_i = 1'b1;
        cyc(5);
        rst_i = 1'b0;
        cyc(2);
        `CHK("reg_mode_float", 1'b0, reg_mode_o)
        role_wdata_i = 2'h2;
        pulse(role_wr_i);
        cyc(2);
        `CHK("role_float", 2'h0, status_o.role_sel)
        $display("strap modes done");
        wrap_up;
    end
endmodule
